// file: verilog/tpg_pkg.sv
// Constants, register map and carrier types of the three-port GPIO block.
// Assumes a 32-bit AXI4-Lite master with word-aligned accesses.
package tpg_pkg;

	// Register indices; byte address is four times the index
	localparam int unsigned ADDR_W = 12;
	localparam logic [7:0] IDX_THIRD_DATA  = 8'h07;
	localparam logic [7:0] IDX_FOURTH_DATA = 8'h08;
	localparam logic [7:0] IDX_FIFTH_DATA  = 8'h09;
	localparam logic [7:0] IDX_THIRD_DIR   = 8'h87;
	localparam logic [7:0] IDX_FOURTH_DIR  = 8'h88;
	localparam logic [7:0] IDX_FIFTH_CTRL  = 8'h89;
	localparam logic [7:0] IDX_ANALOG_CFG  = 8'h9F;

	// Values after reset
	localparam logic [7:0] DIR_RST    = 8'hFF;
	localparam logic [2:0] EDIR_RST   = 3'h7;
	localparam logic [7:0] ANALOG_RST = 8'h00;
	localparam logic [7:0] LATCH_RST  = 8'h00;

	// Control register fields and write masks
	localparam int unsigned CTRL_IBF  = 7;
	localparam int unsigned CTRL_OBF  = 6;
	localparam int unsigned CTRL_INPUT_OVERFLOW_FLAG = 5;
	localparam int unsigned CTRL_MODE = 4;
	localparam logic [7:0] ANALOG_WR_MASK = 8'hCF;
	localparam logic [3:0] PCFG_DIGITAL   = 4'h6;

	// Pin functions of the third port
	localparam int unsigned TIMER_CLK_BIT   = 0;
	localparam int unsigned SECOND_CAP_BIT  = 1;
	localparam int unsigned FIRST_CAP_BIT   = 2;
	localparam int unsigned SER_CLK_BIT     = 3;
	localparam int unsigned SER_DIN_BIT     = 4;
	localparam int unsigned SER_DOUT_BIT    = 5;
	localparam int unsigned XCVR_TX_BIT     = 6;
	localparam int unsigned XCVR_RX_BIT     = 7;

	// Strobe positions on the fifth port
	localparam int unsigned RD_BIT = 0;
	localparam int unsigned WR_BIT = 1;
	localparam int unsigned CS_BIT = 2;

	// Synchroniser width: fifth, fourth, third port pins
	localparam int unsigned SYNC_W = 19;
	localparam logic [18:0] SYNC_RST = 19'h7FFFF;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic sel;
		logic dout;
		logic oe;
		logic ovr_en;
		logic ovr_in;
	} tpg_periph_drv_t;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} tpg_pin_drv_t;

	typedef struct packed {
		logic xcvr_rx;
		logic xcvr_tx;
		logic ser_dout;
		logic ser_din;
		logic ser_clk;
		logic first_cap;
		logic second_cap;
		logic timer_clk;
	} tpg_periph_in_t;

	typedef enum logic [1:0] {
		SLV_IDLE  = 2'b00,
		SLV_WRITE = 2'b01,
		SLV_READ  = 2'b10
	} tpg_slv_state_t;

endpackage : tpg_pkg

// file: verilog/tpg_sync.sv
// Three-flop synchroniser bank for all pin inputs.
// Assumes pins are asynchronous to clk_sys_i.
`timescale 1ns/1ps
module tpg_sync
	import tpg_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	// Pins in, filtered levels out
	input  wire logic [SYNC_W-1:0] pin_i,
	output logic      [SYNC_W-1:0] level_o
);

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;

	// Reset high so that active-low strobes start idle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once stages two and three agree
	for (genvar i = 0; i < SYNC_W; i++) begin : g_flt
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				level_o[i] <= SYNC_RST[i];
			end else if (s2_q[i] == s3_q[i]) begin
				level_o[i] <= s3_q[i];
			end
		end
	end

endmodule : tpg_sync

// file: verilog/tpg_top.sv
// Three-port GPIO block with slave data port, AXI4-Lite registers.
// Assumes pins asynchronous, peripherals on clk_sys_i.
// Notes on behaviour
// RULE1 - Third port direction one makes pin input, driver off.
// RULE2 - Third port direction zero drives the output latch value.
// RULE3 - Enabled peripheral override forces third port pin direction.
// RULE4 - Software avoids read-modify-write of third direction during override.
// RULE5 - Per-pin select chooses latch data or peripheral data.
// RULE6 - Peripheral output enable acts only when peripheral is selected.
// RULE7 - Bits 0-2 carry timer clock and capture functions.
// RULE8 - Bits 3-5 carry serial clock, serial data in, serial data out.
// RULE9 - Bits 6-7 carry transceiver transmit and receive.
// RULE10 - Third port direction resets to all ones.
// RULE11 - Fourth port has eight independently directed pins.
// RULE12 - Fourth port direction resets to all ones.
// RULE13 - Control bit 4 turns fourth port into slave data port.
// RULE14 - Fifth port three pins directed by control bits 2 to 0.
// RULE15 - Software sets strobe pins digital inputs before slave mode.
// RULE16 - Fifth port pins selected analog read as zero.
// RULE17 - Fifth port direction drives pins even when analog.
// RULE18 - After reset fifth port pins are analog, read zero.
// RULE19 - Read strobe low with select drives output latch on pins.
// RULE20 - Write strobe low with select captures pins into input latch.
// RULE21 - Chip select high makes strobes ignored.
// RULE22 - Control holds full flags, overflow, mode, directions; resets 0000-111.
// RULE23 - Unimplemented bits read as zero.
// RULE24 - Slave mode ignores fourth direction; strobes decide driving.
// RULE25 - Full flags held clear outside slave mode; overflow sticky.
// RULE26 - Data writes load latches; reads return pin levels. In slave mode the fourth port reads the input latch.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tpg_top
	import tpg_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               rst_n_i,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire logic               s_axi_awvalid_i,
	output logic                    s_axi_awready_o,
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	input  wire logic               s_axi_wvalid_i,
	output logic                    s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]              s_axi_bresp_o,
	output logic                    s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
	input  wire logic               s_axi_arvalid_i,
	output logic                    s_axi_arready_o,
	output logic [31:0]             s_axi_rdata_o,
	output logic [1:0]              s_axi_rresp_o,
	output logic                    s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i,
	// Third port pins and peripherals
	input  wire logic [7:0]         third_pin_i,
	output tpg_pin_drv_t            third_pin_o,
	input  tpg_periph_drv_t [7:0]   periph_i,
	output tpg_periph_in_t          periph_in_o,
	// Fourth and fifth port pins
	input  wire logic [7:0]         fourth_pin_i,
	output tpg_pin_drv_t            fourth_pin_o,
	input  wire logic [2:0]         fifth_pin_i,
	output logic [2:0]              fifth_dout_o,
	output logic [2:0]              fifth_oe_o,
	// Slave port transfer finished
	output logic                    slave_done_o
);

	// Register state
	logic [7:0]     third_lat_q;
	logic [7:0]     third_dir_q;
	logic [7:0]     fourth_lat_q;
	logic [7:0]     fourth_dir_q;
	logic [7:0]     in_latch_q;
	logic [2:0]     fifth_lat_q;
	logic [2:0]     fifth_dir_q;
	logic           mode_q;
	logic           ibf_q;
	logic           obf_q;
	logic           input_overflow_flag_q;
	logic [7:0]     analog_q;
	tpg_slv_state_t state_q;
	logic           done_q;

	// Bus state
	logic              aw_full_q;
	logic              w_full_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wdata_q;
	logic              wstrb0_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	// Synchronised pin levels
	logic [SYNC_W-1:0] lvl;
	logic [7:0]        sync_c;
	logic [7:0]        sync_d;
	logic [2:0]        sync_e;

	tpg_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.pin_i     ({fifth_pin_i, fourth_pin_i, third_pin_i}),
		.level_o   (lvl)
	);

	assign sync_c = lvl[7:0];
	assign sync_d = lvl[15:8];
	assign sync_e = lvl[18:16];

	// Analog decode: only one field value makes the pins digital
	wire       e_digital = (analog_q[3:0] == PCFG_DIGITAL); // [RULE18]
	wire [2:0] e_analog  = {3{~e_digital}};

	// Strobe decode; chip select gates both strobes
	wire cs_act = mode_q & ~sync_e[CS_BIT];        // [RULE13] [RULE21]
	wire wr_act = cs_act & ~sync_e[WR_BIT];        // [RULE20]
	wire rd_act = cs_act & ~sync_e[RD_BIT];        // [RULE19]

	// Bus decode
	wire       do_wr    = aw_full_q & w_full_q & ~bvalid_q;
	wire       ar_hs    = s_axi_arvalid_i & ~rvalid_q;
	wire       aw_ok    = (awaddr_q[ADDR_W-1:10] == 2'h0);
	wire       ar_ok    = (s_axi_araddr_i[ADDR_W-1:10] == 2'h0);
	wire [7:0] w_idx    = awaddr_q[9:2];
	wire [7:0] r_idx    = s_axi_araddr_i[9:2];
	wire       wen      = do_wr & wstrb0_q & aw_ok;
	wire       wr_c     = wen & (w_idx == IDX_THIRD_DATA);
	wire       wr_d     = wen & (w_idx == IDX_FOURTH_DATA);
	wire       wr_e     = wen & (w_idx == IDX_FIFTH_DATA);
	wire       wr_cdir  = wen & (w_idx == IDX_THIRD_DIR);
	wire       wr_ddir  = wen & (w_idx == IDX_FOURTH_DIR);
	wire       wr_ctrl  = wen & (w_idx == IDX_FIFTH_CTRL);
	wire       wr_an    = wen & (w_idx == IDX_ANALOG_CFG);
	wire       rd_d_reg = ar_hs & ar_ok & (r_idx == IDX_FOURTH_DATA);

	// Address map check shared by both directions
	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == IDX_THIRD_DATA) | (idx == IDX_FOURTH_DATA) |
		         (idx == IDX_FIFTH_DATA) | (idx == IDX_THIRD_DIR) |
		         (idx == IDX_FOURTH_DIR) | (idx == IDX_FIFTH_CTRL) |
		         (idx == IDX_ANALOG_CFG);
	endfunction : mapped

	// Read data views; pins read live except the fourth port in slave mode (input latch), analog pins as zero
	wire [7:0] d_rd    = mode_q ? in_latch_q : sync_d;            // [RULE26]
	wire [7:0] e_rd    = {5'h00, sync_e & ~e_analog};    // [RULE16] [RULE23]
	wire [7:0] ctrl_rd = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0,
	                      fifth_dir_q};                  // [RULE22] [RULE23]
	wire [7:0] an_rd   = analog_q & ANALOG_WR_MASK;               // [RULE23]
	wire [7:0] rd_mux  =
		(r_idx == IDX_THIRD_DATA)  ? sync_c :                     // [RULE26]
		(r_idx == IDX_FOURTH_DATA) ? d_rd :
		(r_idx == IDX_FIFTH_DATA)  ? e_rd :
		(r_idx == IDX_THIRD_DIR)   ? third_dir_q :
		(r_idx == IDX_FOURTH_DIR)  ? fourth_dir_q :
		(r_idx == IDX_FIFTH_CTRL)  ? ctrl_rd :
		(r_idx == IDX_ANALOG_CFG)  ? an_rd : 8'h00;
	wire       r_good  = ar_ok & mapped(r_idx);

	// Slave port events
	wire wr_end = (state_q == SLV_WRITE) & ~wr_act;
	wire rd_beg = (state_q == SLV_IDLE) & ~wr_act & rd_act;
	wire rd_end = (state_q == SLV_READ) & ~rd_act;

	// AXI handshake outputs
	assign s_axi_awready_o = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready_o  = ~w_full_q & ~bvalid_q;
	assign s_axi_arready_o = ~rvalid_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign slave_done_o    = done_q;

	// Write channels are held until both halves arrived
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata_i[7:0];
				wstrb0_q <= s_axi_wstrb_i[0];
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_ok && mapped(w_idx)) ? RESP_OKAY
				                                      : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, r_good ? rd_mux : 8'h00};
			rresp_q  <= r_good ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	// Port latches and direction registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			third_lat_q  <= LATCH_RST;
			fourth_lat_q <= LATCH_RST;
			fifth_lat_q  <= LATCH_RST[2:0];
			third_dir_q  <= DIR_RST;                      // [RULE10]
			fourth_dir_q <= DIR_RST;                      // [RULE12]
			fifth_dir_q  <= EDIR_RST;                     // [RULE22]
			mode_q       <= 1'b0;
			analog_q     <= ANALOG_RST;                   // [RULE18]
		end else begin
			if (wr_c) third_lat_q <= wdata_q;             // [RULE26]
			if (wr_d) fourth_lat_q <= wdata_q;
			if (wr_e) fifth_lat_q <= wdata_q[2:0];
			if (wr_cdir) third_dir_q <= wdata_q;
			if (wr_ddir) fourth_dir_q <= wdata_q;         // [RULE11]
			if (wr_ctrl) begin
				fifth_dir_q <= wdata_q[2:0];              // [RULE14]
				mode_q      <= wdata_q[CTRL_MODE];        // [RULE13]
			end
			if (wr_an) analog_q <= wdata_q & ANALOG_WR_MASK;
		end
	end

	// Slave transfer sequencer; a write outranks a read
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q    <= SLV_IDLE;
			done_q     <= 1'b0;
			in_latch_q <= LATCH_RST;
		end else begin
			done_q <= wr_end | rd_end;
			case (state_q)
				SLV_IDLE: begin
					if (wr_act) begin
						state_q <= SLV_WRITE;
					end else if (rd_act) begin
						state_q <= SLV_READ;
					end
				end
				SLV_WRITE: begin
					// Data and strobe share the same sync latency
					if (!wr_act) begin
						in_latch_q <= sync_d;             // [RULE20]
						state_q    <= SLV_IDLE;
					end
				end
				SLV_READ: begin
					if (!rd_act) begin
						state_q <= SLV_IDLE;
					end
				end
				default: state_q <= SLV_IDLE;
			endcase
		end
	end

	// Flags: every hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ibf_q  <= 1'b0;
			obf_q  <= 1'b0;
			input_overflow_flag_q <= 1'b0;
		end else begin
			if (!mode_q) begin
				ibf_q <= 1'b0;                            // [RULE25]
				obf_q <= 1'b0;
			end else begin
				if (wr_end) ibf_q <= 1'b1;
				else if (rd_d_reg) ibf_q <= 1'b0;
				if (wr_d) obf_q <= 1'b1;
				else if (rd_beg) obf_q <= 1'b0;
			end
			if (wr_end && ibf_q && mode_q) input_overflow_flag_q <= 1'b1; // [RULE25]
			else if (wr_ctrl) input_overflow_flag_q <= wdata_q[CTRL_INPUT_OVERFLOW_FLAG];
		end
	end

	// Third port drivers, with per-pin peripheral takeover
	for (genvar i = 0; i < 8; i++) begin : g_third
		wire eff_in = periph_i[i].ovr_en ? periph_i[i].ovr_in
		                                 : third_dir_q[i]; // [RULE3] [RULE1]
		// Open-drain peripherals release the pin through their enable
		assign third_pin_o.oe[i] = ~eff_in &
			(periph_i[i].sel ? periph_i[i].oe : 1'b1);   // [RULE2] [RULE6]
		assign third_pin_o.dout[i] = periph_i[i].sel ? periph_i[i].dout
		                                             : third_lat_q[i]; // [RULE5]
	end

	// Peripheral inputs from the third port pins
	assign periph_in_o.timer_clk  = sync_c[TIMER_CLK_BIT];       // [RULE7]
	assign periph_in_o.second_cap = sync_c[SECOND_CAP_BIT];      // [RULE7]
	assign periph_in_o.first_cap  = sync_c[FIRST_CAP_BIT];       // [RULE7]
	assign periph_in_o.ser_clk    = sync_c[SER_CLK_BIT];         // [RULE8]
	assign periph_in_o.ser_din    = sync_c[SER_DIN_BIT];         // [RULE8]
	assign periph_in_o.ser_dout   = sync_c[SER_DOUT_BIT];        // [RULE8]
	assign periph_in_o.xcvr_tx    = sync_c[XCVR_TX_BIT];         // [RULE9]
	assign periph_in_o.xcvr_rx    = sync_c[XCVR_RX_BIT];         // [RULE9]

	// Fourth port: direction register, or read strobe in slave mode
	assign fourth_pin_o.dout = fourth_lat_q;                     // [RULE19]
	assign fourth_pin_o.oe   = mode_q ? {8{rd_act}}
	                                  : ~fourth_dir_q;   // [RULE24] [RULE11]

	// Fifth port: direction bits rule even for analog pins
	assign fifth_dout_o = fifth_lat_q;
	assign fifth_oe_o   = ~fifth_dir_q;                          // [RULE17]

	// Checks
	chk_third_plain: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(periph_i == '0) |-> third_pin_o.oe == ~third_dir_q &&
		third_pin_o.dout == third_lat_q)   // [RULE1] [RULE2]
		else $error("third port pin drive mismatch");

	chk_periph_oe_gate: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(periph_i[0].sel && !periph_i[0].oe) |-> !third_pin_o.oe[0]) // [RULE6]
		else $error("peripheral enable ignored");

	chk_fourth_gpio: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!mode_q |-> fourth_pin_o.oe == ~fourth_dir_q)   // [RULE11]
		else $error("fourth port direction not applied");

	chk_fourth_slave: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(mode_q && sync_e[CS_BIT]) |-> fourth_pin_o.oe == 8'h00) // [RULE24]
		else $error("data pins driven while not selected");

	chk_cs_ignore: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(state_q == SLV_IDLE && sync_e[CS_BIT]) |=>
		state_q == SLV_IDLE)   // [RULE21]
		else $error("strobe taken without chip select");

	chk_write_capture: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(wr_end && mode_q) |=> ibf_q && done_q &&
		in_latch_q == $past(sync_d))   // [RULE20]
		else $error("slave write not captured");

	chk_flags_clear: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!mode_q |=> !ibf_q && !obf_q)   // [RULE25]
		else $error("full flags set outside slave mode");

	chk_overflow: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(wr_end && ibf_q && mode_q) |=> input_overflow_flag_q ##1 input_overflow_flag_q [*2]) // [RULE25]
		else $error("overflow not flagged or not sticky");

	chk_analog_zero: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!e_digital |-> e_rd == 8'h00)   // [RULE16]
		else $error("analog pin reads nonzero");

	chk_read_answer: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		(ar_hs && r_idx == IDX_FIFTH_CTRL && ar_ok) |=>
		rvalid_q && rdata_q[3] == 1'b0 && rdata_q[31:8] == 24'h0) // [RULE23]
		else $error("control read wrong");

	cov_slave_write: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) wr_end && mode_q);
	cov_slave_read: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) rd_end);
	cov_overflow: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) $rose(input_overflow_flag_q));
	cov_unmapped: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) bvalid_q && bresp_q == RESP_SLVERR);

endmodule : tpg_top

// file: sim/tpg_partner.sv
// External microprocessor on the slave data port strobes and data pins.
// Assumes the bench resolves the shared data bus and feeds it back here.
`timescale 1ns/1ps
module tpg_partner (
	// Clock and resolved data bus
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] bus_i,
	// Strobes: bit0 read_n, bit1 write_n, bit2 select_n
	output logic      [2:0] strobe_n_o,
	output logic      [7:0] data_o
);
	initial begin
		strobe_n_o = 3'h7;
		data_o = 8'h00;
	end

	// One bus cycle; released data shows its inverse, never a stale value
	task automatic xfer(input logic rd, input logic cs_n,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		strobe_n_o <= {cs_n, rd, ~rd};
		if (!rd) data_o <= d;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		q = bus_i;
		@(posedge clk_sys_i);
		strobe_n_o <= 3'h7;
		// Data held through release, sync delay applies to it as well
		repeat (6) @(posedge clk_sys_i);
		data_o <= ~data_o;
		repeat (6) @(posedge clk_sys_i);
	endtask : xfer
endmodule : tpg_partner

// file: sim/testbench.sv
// Self-checking bench: AXI4-Lite register tasks, pins and slave port.
// Assumes tpg_top and tpg_partner; pins are resolved here from enables.
`timescale 1ns/1ps
module testbench
	import tpg_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic awready, wready, bvalid, arready, rvalid, done;
	logic [1:0] bresp, rresp, rr;
	logic [7:0] tb_third = 8'h3C, third_in, fourth_in, p_data, pq;
	logic [2:0] fifth_in, fifth_dout, fifth_oe, p_strobe;
	tpg_pin_drv_t third_o, fourth_o;
	tpg_periph_drv_t [7:0] periph = '0;
	tpg_periph_in_t periph_in;
	int fail_count = 0;
	int check_count = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	// Wire levels from the DUT enables; the other party drives when they are off
	assign third_in = (third_o.oe & third_o.dout) | (~third_o.oe & tb_third);
	assign fourth_in = (fourth_o.oe & fourth_o.dout) | (~fourth_o.oe & p_data);
	assign fifth_in = (fifth_oe & fifth_dout) | (~fifth_oe & p_strobe);

	tpg_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .third_pin_i(third_in),
		.third_pin_o(third_o), .periph_i(periph),
		.periph_in_o(periph_in), .fourth_pin_i(fourth_in),
		.fourth_pin_o(fourth_o), .fifth_pin_i(fifth_in),
		.fifth_dout_o(fifth_dout), .fifth_oe_o(fifth_oe),
		.slave_done_o(done));

	tpg_partner PARTNER (.clk_sys_i(clk_sys_i), .bus_i(fourth_in),
		.strobe_n_o(p_strobe), .data_o(p_data));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Write one register; each channel released once taken
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er);
		logic aw_h, w_h, b_h;
		b_h = 1'b0;
		@(posedge clk_sys_i);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_h) begin
			// Ready is settled mid-cycle, so the edge outcome is known here
			@(negedge clk_sys_i);
			aw_h = awvalid & awready;
			w_h = wvalid & wready;
			b_h = bvalid;
			if (b_h) chk({30'h0, bresp}, {30'h0, er});
			@(posedge clk_sys_i);
			if (aw_h) awvalid <= 1'b0;
			if (w_h) wvalid <= 1'b0;
			if (b_h) bready <= 1'b0;
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_h, r_h;
		r_h = 1'b0;
		@(posedge clk_sys_i);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_h) begin
			@(negedge clk_sys_i);
			ar_h = arvalid & arready;
			r_h = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys_i);
			if (ar_h) arvalid <= 1'b0;
			if (r_h) rready <= 1'b0;
		end
	endtask : axi_rd

	// Read and compare data and an OKAY response
	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
		axi_rd(idx, q, rr);
		// Data and response compared apart; one 32-bit word holds neither pair
		chk(q, {24'h0, exp});
		chk({30'h0, rr}, {30'h0, RESP_OKAY});
	endtask : chk_rd

	task automatic finish_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// Watchdog well beyond the whole sequence
	initial begin
		#(20000 * 100);
		fail_count++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		chk_rd(IDX_THIRD_DIR, 8'hFF);
		chk_rd(IDX_FOURTH_DIR, 8'hFF);
		chk_rd(IDX_FIFTH_CTRL, 8'h07);
		chk_rd(IDX_FIFTH_DATA, 8'h00);
		chk({16'h0, third_o.oe, fourth_o.oe}, 32'h0);
		axi_wr(IDX_FIFTH_CTRL, 8'h0F, RESP_OKAY);
		chk_rd(IDX_FIFTH_CTRL, 8'h07);
		axi_rd(8'h10, q, rr);
		chk(q, 32'h0);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		axi_wr(8'h10, 8'hFF, RESP_SLVERR);
		// Third port as plain outputs on the upper half
		axi_wr(IDX_THIRD_DATA, 8'hA5, RESP_OKAY);
		axi_wr(IDX_THIRD_DIR, 8'h0F, RESP_OKAY); // no bit ops
		chk({third_o.oe, third_o.dout}, 32'hF0A5);
		// Peripherals: select with and without enable, forced direction
		periph[7] <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		periph[6] <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		periph[0] <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		repeat (6) @(posedge clk_sys_i);
		chk({third_o.oe, third_o.dout}, 32'hB165);
		chk({24'h0, periph_in}, 32'h2D);
		chk_rd(IDX_THIRD_DATA, 8'h2D);
		axi_wr(IDX_FOURTH_DATA, 8'h96, RESP_OKAY);
		axi_wr(IDX_FOURTH_DIR, 8'h0F, RESP_OKAY);
		chk({fourth_o.oe, fourth_o.dout}, 32'hF096);
		// Fifth pins driven while still analog, and read as zero
		axi_wr(IDX_FIFTH_CTRL, 8'h00, RESP_OKAY);
		chk({29'h0, fifth_oe}, 32'h7);
		chk_rd(IDX_FIFTH_DATA, 8'h00);
		axi_wr(IDX_FIFTH_CTRL, 8'h07, RESP_OKAY);
		axi_wr(IDX_ANALOG_CFG, {4'h0, PCFG_DIGITAL}, RESP_OKAY);
		repeat (6) @(posedge clk_sys_i);
		chk_rd(IDX_FIFTH_DATA, 8'h07);
		// Slave mode: direction of fourth port no longer matters
		axi_wr(IDX_FIFTH_CTRL, 8'h17, RESP_OKAY);
		axi_wr(IDX_FOURTH_DIR, 8'h00, RESP_OKAY);
		repeat (6) @(posedge clk_sys_i);
		chk({24'h0, fourth_o.oe}, 32'h0);
		PARTNER.xfer(1'b0, 1'b0, 8'h3C, pq);
		chk_rd(IDX_FIFTH_CTRL, 8'h97);
		PARTNER.xfer(1'b0, 1'b0, 8'hC3, pq);
		chk_rd(IDX_FIFTH_CTRL, 8'hB7);
		chk_rd(IDX_FOURTH_DATA, 8'hC3);
		chk_rd(IDX_FIFTH_CTRL, 8'h37);
		axi_wr(IDX_FOURTH_DATA, 8'h5A, RESP_OKAY);
		chk_rd(IDX_FIFTH_CTRL, 8'h77);
		PARTNER.xfer(1'b1, 1'b0, 8'h00, pq);
		chk({24'h0, pq}, 32'h5A);
		chk_rd(IDX_FIFTH_CTRL, 8'h37);
		PARTNER.xfer(1'b0, 1'b1, 8'h11, pq);
		chk_rd(IDX_FIFTH_CTRL, 8'h37);
		PARTNER.xfer(1'b1, 1'b1, 8'h00, pq);
		chk({24'h0, pq}, {24'h0, ~8'h11});
		// Leaving slave mode: full flags clear, overflow stays
		axi_wr(IDX_FIFTH_CTRL, 8'h27, RESP_OKAY);
		chk_rd(IDX_FIFTH_CTRL, 8'h27);
		axi_wr(IDX_FIFTH_CTRL, 8'h07, RESP_OKAY);
		chk_rd(IDX_FIFTH_CTRL, 8'h07);
		chk({24'h0, fourth_o.oe}, 32'hFF);
		finish_test();
	end
endmodule : testbench
